// >>> hw/grant_lock_map.svh
/*
  Timing constants and reset values for the dual-port grant and lock arbiter.
  Assumes it is included by bare name from the arbiter package or modules.
*/
`ifndef GRANT_LOCK_MAP_SVH
`define GRANT_LOCK_MAP_SVH

`define GL_GRANT_RESET 1'b0
`define GL_DELAY_SHORT 2'h1
`define GL_DELAY_LONG 2'h2
`define GL_REFRESH_MIN_NS 40
`define GL_CLK_PERIOD_NS 4
`define GL_REFRESH_CYCLES ((`GL_REFRESH_MIN_NS + `GL_CLK_PERIOD_NS - 1) / `GL_CLK_PERIOD_NS)

`endif

// >>> hw/grant_lock_pkg.sv
/*
  Types shared by the dual-port grant and lock arbiter.
  Assumes the map header supplies all numeric constants.
*/
package grant_lock_pkg;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_REFRESH = 2'b01,
    ARB_SETTLE = 2'b10,
    ARB_ACCESS = 2'b11
  } arb_state_t;

  typedef struct packed {
    logic request;
    logic busy;
  } port_req_t;

endpackage

// >>> hw/grant_switch_delay.sv
/*
  Counts the clock periods between a grant change and the row strobe of the
  new owner's access. Assumes start is a one-cycle pulse on the grant edge.
*/
`timescale 1ns/10ps
`include "grant_lock_map.svh"

module grant_switch_delay (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic start, // Pulse on the grant change.
  input wire logic long_delay, // High selects two periods, low one.
  output logic done // Pulse when the delay has run out.
);

  logic [1:0] count_q;
  logic [1:0] count_d;
  logic [1:0] load_value;
  logic done_d;

  assign load_value = long_delay ? `GL_DELAY_LONG : `GL_DELAY_SHORT;
  assign count_d = start ? load_value : (count_q != 2'h0 ? count_q - 2'h1 : 2'h0);
  assign done_d = (count_q == 2'h1) && !start;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_d;
    end
  end

  assign done = done_d;

endmodule // grant_switch_delay

// >>> hw/dual_port_dram_grant_lock.sv
/*
  Arbiter that hands one DRAM array to port A or port B, with a lock input and
  refresh priority. Assumes both requests are synchronous to REF_CLK and that
  the system steers shared address and control inputs by the grant output.
*/
// What this block does
// - A port kept out of the array gets wait states until it may reach memory.
// - The port-B grant output is high when port B owns the array and low for port A.
// - A waiting ungranted port takes the grant on a rising edge once the owner's request and hold are negated and no refresh is requested.
// - The row strobe for the new owner comes one or two clock periods after the grant switched, never before.
// - The grant stays put until the other port requests while the owner is not accessing.
// - While hold is asserted the grant stays fixed, yet refreshes still run.
// - Hold may be used by whichever port is currently granted.
// - The granted port ranks first, then refresh, then the ungranted one, and the last owner stays granted.
// - The grant moves to port B only on an edge where port A neither requests nor holds and port B requests.
// - An ungranted port B access starts on the first or second edge after the grant, as configured.
`timescale 1ns/10ps
`include "grant_lock_map.svh"

module dual_port_dram_grant_lock (
  input wire logic REF_CLK, // System clock, 250 MHz.
  input wire logic RST, // Synchronous reset, active high.
  input wire logic FIRST_PORT_ACCESS_REQUEST, // Port A access request, active high.
  input wire logic SECOND_PORT_ACCESS_REQUEST, // Port B access request, active high.
  input wire logic HOLD_LOCK, // Lock of the granted port, buffered per grant.
  input wire logic REFRESH_REQUEST, // Refresh wanted, active high.
  input wire logic LONG_GRANT_DELAY, // Configuration: two periods instead of one.
  output logic SECOND_PORT_OWNS_ARRAY, // Grant: high means port B owns the array.
  output logic ROW_STROBE, // Row strobe for the owner's access, active high.
  output logic REFRESH_ACTIVE, // Refresh cycle in progress.
  output logic FIRST_PORT_WAIT, // Wait states to port A.
  output logic SECOND_PORT_WAIT // Wait states to port B.
);

  grant_lock_pkg::arb_state_t state_q;
  grant_lock_pkg::arb_state_t state_d;
  grant_lock_pkg::port_req_t port_a;
  grant_lock_pkg::port_req_t port_b;
  logic grant_q;
  logic grant_d;
  logic [3:0] refresh_count_q;
  logic [3:0] refresh_count_d;
  logic owner_req;
  logic other_req;
  logic switch_grant;
  logic delay_done;
  logic refresh_done;

  // Requests are already on REF_CLK, so no synchroniser sits here.
  assign port_a = '{request: FIRST_PORT_ACCESS_REQUEST, busy: FIRST_PORT_ACCESS_REQUEST | (HOLD_LOCK & !grant_q)};
  assign port_b = '{request: SECOND_PORT_ACCESS_REQUEST, busy: SECOND_PORT_ACCESS_REQUEST | (HOLD_LOCK & grant_q)};

  assign owner_req = grant_q ? port_b.request : port_a.request;
  assign other_req = grant_q ? port_a.request : port_b.request;

  // The hold applies to whoever owns the grant, so the owner's busy term carries it.
  assign switch_grant = (state_q == grant_lock_pkg::ARB_IDLE) && !REFRESH_REQUEST &&
                        (grant_q ? (!port_b.busy && port_a.request)
                                 : (!port_a.busy && port_b.request));

  assign grant_d = switch_grant ? !grant_q : grant_q;

  assign refresh_done = (refresh_count_q == 4'h1);
  assign refresh_count_d = (state_q == grant_lock_pkg::ARB_IDLE && REFRESH_REQUEST && !owner_req) ?
                           4'(`GL_REFRESH_CYCLES) :
                           (refresh_count_q != 4'h0 ? refresh_count_q - 4'h1 : 4'h0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      grant_lock_pkg::ARB_IDLE: begin
        if (REFRESH_REQUEST && !owner_req) begin
          state_d = grant_lock_pkg::ARB_REFRESH;
        end else if (switch_grant) begin
          state_d = grant_lock_pkg::ARB_SETTLE;
        end else if (owner_req) begin
          state_d = grant_lock_pkg::ARB_ACCESS;
        end
      end
      grant_lock_pkg::ARB_REFRESH: begin
        if (refresh_done) begin
          state_d = grant_lock_pkg::ARB_IDLE;
        end
      end
      grant_lock_pkg::ARB_SETTLE: begin
        if (delay_done) begin
          state_d = owner_req ? grant_lock_pkg::ARB_ACCESS : grant_lock_pkg::ARB_IDLE;
        end
      end
      grant_lock_pkg::ARB_ACCESS: begin
        if (!owner_req) begin
          state_d = grant_lock_pkg::ARB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= grant_lock_pkg::ARB_IDLE;
      grant_q <= `GL_GRANT_RESET;
      refresh_count_q <= 4'h0;
    end else begin
      state_q <= state_d;
      grant_q <= grant_d;
      refresh_count_q <= refresh_count_d;
    end
  end

  grant_switch_delay settle_timer (
    .clk(REF_CLK),
    .rst(RST),
    .start(switch_grant),
    .long_delay(LONG_GRANT_DELAY),
    .done(delay_done)
  );

  // The grant is a flop so the external buffers see a clean select.
  assign SECOND_PORT_OWNS_ARRAY = grant_q;
  assign ROW_STROBE = (state_q == grant_lock_pkg::ARB_ACCESS);
  assign REFRESH_ACTIVE = (state_q == grant_lock_pkg::ARB_REFRESH);
  // Requester waits until it owns the grant and its access is running.
  assign FIRST_PORT_WAIT = port_a.request && !(!grant_q && state_q == grant_lock_pkg::ARB_ACCESS);
  assign SECOND_PORT_WAIT = port_b.request && !(grant_q && state_q == grant_lock_pkg::ARB_ACCESS);

  logic unused_other;
  assign unused_other = other_req;

endmodule // dual_port_dram_grant_lock

// >>> bench/grant_lock_monitor.sv
/* Assertions on the grant arbiter ports.
   Assumes it is bound to the arbiter top module. */
`timescale 1ns/10ps
module grant_lock_monitor (
  input wire logic REF_CLK, RST, FIRST_PORT_ACCESS_REQUEST, SECOND_PORT_ACCESS_REQUEST, HOLD_LOCK,
  input wire logic REFRESH_REQUEST, LONG_GRANT_DELAY, SECOND_PORT_OWNS_ARRAY, ROW_STROBE,
  input wire logic REFRESH_ACTIVE, FIRST_PORT_WAIT, SECOND_PORT_WAIT
);
  wire g = SECOND_PORT_OWNS_ARRAY;
  wire rs = ROW_STROBE;
  wire ra = FIRST_PORT_ACCESS_REQUEST;
  wire rb = SECOND_PORT_ACCESS_REQUEST;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_port_b_waits: assert property (rb && !g |-> SECOND_PORT_WAIT) else $error("port B not held off");
  a_port_a_waits: assert property (ra && g |-> FIRST_PORT_WAIT) else $error("port A not held off");
  a_lock_keeps_grant: assert property (HOLD_LOCK |=> $stable(g)) else $error("grant moved under lock");
  a_b_takes_idle: assert property ($rose(g) |-> !$past(ra) && !$past(HOLD_LOCK) && $past(rb)) else $error("grant to B while A busy");
  a_a_takes_idle: assert property ($fell(g) |-> $past(ra) && !$past(rb) && !$past(HOLD_LOCK)) else $error("grant to A while B busy");
  a_short_strobe_delay: assert property ($changed(g) && !LONG_GRANT_DELAY |-> !rs ##1 rs) else $error("short delay");
  a_long_strobe_delay: assert property ($changed(g) && LONG_GRANT_DELAY |-> !rs ##1 !rs ##1 rs) else $error("long delay");
  a_grant_reset: assert property (disable iff (1'b0) RST |=> !g) else $error("grant set after reset");
  cover property ($rose(g));
  cover property ($fell(g));
  cover property (HOLD_LOCK && REFRESH_ACTIVE);
endmodule // grant_lock_monitor
bind dual_port_dram_grant_lock grant_lock_monitor i_mon (.*);

// >>> bench/cpu_pair_model.sv
/* Two CPUs sharing the array through grant-steered buffers.
   Assumes start pulses arrive just after a rising edge. */
`timescale 1ns/10ps
module cpu_pair_model (
  input wire logic clk, // System clock.
  input wire logic go_a, // Start a port A access.
  input wire logic go_b, // Start a port B access.
  input wire logic lock_a, // Port A lock wish.
  input wire logic lock_b, // Port B lock wish.
  input wire logic grant, // Grant from the arbiter.
  input wire logic strobe, // Row strobe from the arbiter.
  output logic req_a = 1'b0, // Port A request.
  output logic req_b = 1'b0, // Port B request.
  output logic hold // Lock passed by the grant buffers.
);
  assign hold = grant ? lock_b : lock_a;
  always @(posedge clk) begin
    if (go_a) req_a <= 1'b1;
    else if (strobe && !grant) req_a <= 1'b0;
    if (go_b) req_b <= 1'b1;
    else if (strobe && grant) req_b <= 1'b0;
  end
endmodule // cpu_pair_model

// >>> bench/dual_port_dram_grant_lock_test.sv
/* Self-checking bench for the grant arbiter.
   Assumes the CPU pair model drives the requests. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin cmp_count++; if ((e) !== (a)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module dual_port_dram_grant_lock_test;
  logic clk = 0, rst = 1, go_a = 0, go_b = 0, lock_a = 0, lock_b = 0, refresh = 0, long_d = 0, rs_q = 0, exp_g;
  logic req_a, req_b, hold, grant, strobe, ref_act, wait_a, wait_b;
  logic q[$];
  int fails = 0, cmp_count = 0, r;
  integer seed = 32'hf53efa88;
  initial forever #2 clk = ~clk;
  dual_port_dram_grant_lock i_dut (.REF_CLK(clk), .RST(rst), .FIRST_PORT_ACCESS_REQUEST(req_a),
    .SECOND_PORT_ACCESS_REQUEST(req_b), .HOLD_LOCK(hold), .REFRESH_REQUEST(refresh), .LONG_GRANT_DELAY(long_d),
    .SECOND_PORT_OWNS_ARRAY(grant), .ROW_STROBE(strobe), .REFRESH_ACTIVE(ref_act), .FIRST_PORT_WAIT(wait_a),
    .SECOND_PORT_WAIT(wait_b));
  cpu_pair_model i_cpu (.clk(clk), .go_a(go_a), .go_b(go_b), .lock_a(lock_a), .lock_b(lock_b), .grant(grant),
    .strobe(strobe), .req_a(req_a), .req_b(req_b), .hold(hold));
  always @(posedge clk) begin
    rs_q <= strobe;
    if (strobe && !rs_q && q.size() > 0) begin
      exp_g = q.pop_front();
      `CHK("grant at strobe", exp_g, grant)
    end
  end
  task automatic access(input logic p);
    q.push_back(p);
    if (p) go_b <= 1'b1;
    else go_a <= 1'b1;
    @(posedge clk);
    {go_a, go_b} <= 2'b00;
    for (int i = 0; i < 30 && !(strobe && grant === p); i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 2; k++) begin
      rst <= 1'b1;
      long_d <= k[0];
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("grant after reset", 1'b0, grant)
      repeat (12) begin
        r = $random(seed);
        access(r[0]);
      end
      $display("random pass %0d done", k);
    end
    access(1'b0);
    lock_a <= 1'b1;
    go_b <= 1'b1;
    refresh <= 1'b1;
    @(posedge clk);
    go_b <= 1'b0;
    for (int i = 0; i < 30 && ref_act !== 1'b1; i++) @(posedge clk);
    `CHK("refresh under lock", 1'b1, ref_act)
    refresh <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK("grant under lock", 1'b0, grant)
    `CHK("port b waits", 1'b1, wait_b)
    lock_a <= 1'b0;
    access(1'b1);
    `CHK("pending strobes", 0, q.size())
    $display("lock test done");
    stop_test;
  end
  initial begin
    #20000;
    fails++;
    stop_test;
  end
endmodule // dual_port_dram_grant_lock_test
